// ---- inc/uart_pkg.sv ----
// Constants, register layout and state types of the serial transceiver.
// Assumes a single hclk domain and an AHB-Lite slave port for the registers.
package uart_pkg;
  localparam logic [7:0]  MODE_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  localparam logic [7:0]  TXD_OFS         = 8'h08;
  localparam logic [7:0]  RXD_OFS         = 8'h0C;
  localparam logic [7:0]  BRG_OFS         = 8'h10;
  localparam int          MODE_EN_BIT     = 15;
  localparam int          MODE_INFRARED_ENABLE_BIT_BIT   = 12;
  localparam int          MODE_UEN_LSB    = 8;
  localparam int          MODE_HIGH_SPEED_BAUD_SELECT_BIT   = 3;
  localparam int          MODE_PDSEL_LSB  = 1;
  localparam int          MODE_STSEL_BIT  = 0;
  localparam int          STAT_TXISEL_LSB = 14;
  localparam int          STAT_TXBRK_BIT  = 11;
  localparam int          STAT_TXEN_BIT   = 10;
  localparam int          STAT_TXBF_BIT   = 9;
  localparam int          STAT_TRMT_BIT   = 8;
  localparam int          STAT_RXISEL_LSB = 6;
  localparam int          STAT_PARITY_ERROR_FLAG_BIT   = 3;
  localparam int          STAT_FRAMING_ERROR_FLAG_BIT   = 2;
  localparam int          STAT_RECEIVE_OVERRUN_FLAG_BIT   = 1;
  localparam int          STAT_RXDA_BIT   = 0;
  localparam logic [15:0] MODE_RST        = 16'h0000;
  localparam logic [15:0] BRG_RST         = 16'h0000;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          TX_WIDTH        = 9;
  localparam int          RX_WIDTH        = 11;
  localparam logic [4:0]  TICKS_LO        = 5'h10;
  localparam logic [4:0]  TICKS_HI        = 5'h04;
  localparam logic [3:0]  BREAK_BITS      = 4'hD;
  localparam logic [4:0]  IR_PULSE_TICKS  = 5'h03;
  localparam logic [5:0]  RX_NEAR_FULL    = 6'h18;
  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;
endpackage

// ---- rtl/uart_tx_rx_break_irda.sv ----
// Serial transceiver with break and sync, flow control pins and infrared
// codec, plus one FIFO that buffers characters in each direction.
// Assumes one AHB-Lite master, pins arriving from outside the hclk domain.
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps

module char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // Filling side.
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Draining side.
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  // Fill level.
  output logic [$clog2(DEPTH):0]          count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              do_push = in_valid & in_ready;
  wire              do_pop  = out_valid & out_ready;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign count     = count_reg;

  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= do_push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_reg  <= count_reg + {{AW{1'b0}}, do_push}
                              - {{AW{1'b0}}, do_pop};
    end
  end
endmodule

module uart_tx_rx_break_irda (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial and handshake pins.
  input  wire logic        serial_receive_pin,
  output logic             serial_transmit_pin,
  output logic             serial_transmit_oe,
  input  wire logic        clear_to_send_pin_n,
  output logic             request_to_send_pin_n,
  output logic             request_to_send_oe,
  // Interrupt requests towards the interrupt controller.
  output logic             tx_irq,
  output logic             rx_irq
);
  // Register state.
  logic [15:0]        mode_reg;
  logic [15:0]        brg_reg;
  logic [1:0]         txisel_reg;
  logic [1:0]         rxisel_reg;
  logic               transmit_enable_bit_reg;
  logic               send_break_bit_reg;
  logic               receive_overrun_flag_reg;
  logic [31:0]        hrdata_reg;
  logic               dp_wr_reg;
  logic [7:0]         dp_ofs_reg;
  // Pin synchronisers.
  logic [1:0]         rx_sync_reg;
  logic [1:0]         cts_sync_reg;
  // Baud generator, interrupts and pins.
  logic [15:0]        brg_cnt_reg;
  logic               bclk_reg;
  logic               txen_d1_reg;
  logic               txen_d2_reg;
  logic               tx_irq_reg;
  logic               rx_irq_reg;
  logic               tx_pin_reg;
  logic               rts_reg;
  logic [4:0]         ir_hold_reg;
  // Transmitter.
  uart_pkg::tx_state_t tx_state_reg;
  logic [4:0]         tx_sub_reg;
  logic [3:0]         tx_cnt_reg;
  logic [8:0]         tx_shift_reg;
  logic               tx_par_reg;
  // Receiver.
  uart_pkg::rx_state_t rx_state_reg;
  logic [4:0]         rx_sub_reg;
  logic [3:0]         rx_cnt_reg;
  logic [8:0]         rx_shift_reg;
  logic               rx_parity_error_flag_reg;

  // Mode fields.
  wire        mode_en = mode_reg[uart_pkg::MODE_EN_BIT];
  wire        high_speed_baud_select    = mode_reg[uart_pkg::MODE_HIGH_SPEED_BAUD_SELECT_BIT];
  wire [1:0]  pin_enable_field     = mode_reg[uart_pkg::MODE_UEN_LSB +: 2];
  wire [1:0]  pdsel   = mode_reg[uart_pkg::MODE_PDSEL_LSB +: 2];
  wire        two_stop = mode_reg[uart_pkg::MODE_STSEL_BIT];
  wire        nine_bit = (pdsel == 2'h3);
  wire        par_en   = (pdsel == 2'h1) | (pdsel == 2'h2);
  wire        par_odd  = (pdsel == 2'h2);
  wire [3:0]  last_bit = nine_bit ? 4'h8 : 4'h7;
  wire        ir_on = mode_reg[uart_pkg::MODE_INFRARED_ENABLE_BIT_BIT] & ~high_speed_baud_select;
  wire [4:0]  tpb = high_speed_baud_select ? uart_pkg::TICKS_HI : uart_pkg::TICKS_LO;

  // FIFO wires.
  wire        tx_in_ready;
  wire        tx_out_valid;
  wire [8:0]  tx_out_data;
  wire [5:0]  tx_count;
  wire        rx_in_ready;
  wire        rx_out_valid;
  wire [10:0] rx_out_data;
  wire [5:0]  rx_count;

  // Bus decode; only the low address byte selects a register.
  wire        addr_ok = hsel & hready & htrans[1];
  wire        wr_mode = dp_wr_reg & (dp_ofs_reg == uart_pkg::MODE_OFS);
  wire        wr_stat = dp_wr_reg & (dp_ofs_reg == uart_pkg::STAT_OFS);
  wire        wr_brg  = dp_wr_reg & (dp_ofs_reg == uart_pkg::BRG_OFS);
  wire        wr_tx   = dp_wr_reg & (dp_ofs_reg == uart_pkg::TXD_OFS);
  // A write to a full FIFO stalls the bus while transmit is enabled; with transmit disabled the write is dropped.
  wire        tx_stall = wr_tx & ~tx_in_ready & transmit_enable_bit_reg;
  wire        tx_push  = wr_tx & tx_in_ready;
  wire        rd_rx   = addr_ok & ~hwrite & (haddr[7:0] == uart_pkg::RXD_OFS);
  wire        rx_pop  = rd_rx & rx_out_valid;
  wire        transmit_enable_bit_set = wr_stat & hwdata[uart_pkg::STAT_TXEN_BIT]
                          & ~transmit_enable_bit_reg;

  // Baud tick; a fresh transmit enable restarts it from zero.
  wire        brg_tick = (brg_cnt_reg == 16'h0000);
  wire        brg_restart = transmit_enable_bit_set | ~mode_en;

  // Transmit bit timing and line value.
  wire        tx_bit_end = brg_tick & (tx_sub_reg == tpb - 5'h01);
  wire        cts_ok = (pin_enable_field != 2'h2) | ~cts_sync_reg[1];
  wire        tx_start = (tx_state_reg == uart_pkg::TX_IDLE) & mode_en
                         & transmit_enable_bit_reg & tx_out_valid & cts_ok & brg_tick;
  wire        tx_done = (tx_state_reg == uart_pkg::TX_STOP) & tx_bit_end
                        & (~two_stop | (tx_cnt_reg == 4'h1));
  wire        brk_done = (tx_state_reg == uart_pkg::TX_BREAK) & tx_bit_end
                         & (tx_cnt_reg == uart_pkg::BREAK_BITS - 4'h1);
  wire [8:0]  tx_char = nine_bit ? tx_out_data : {1'b0, tx_out_data[7:0]};
  logic       tx_bit;
  always_comb begin
    unique case (tx_state_reg)
      uart_pkg::TX_START, uart_pkg::TX_BREAK: tx_bit = 1'b0;
      uart_pkg::TX_DATA:  tx_bit = tx_shift_reg[0];
      uart_pkg::TX_PAR:   tx_bit = tx_par_reg;
      default:            tx_bit = 1'b1;
    endcase
  end
  // Infrared pulse is 3/16 of a bit for each zero, none for a one.
  wire        ir_tx = ~tx_bit & (tx_sub_reg < uart_pkg::IR_PULSE_TICKS);
  wire        tx_line = ir_on ? ir_tx : tx_bit;

  // Transmit interrupt event chosen by the select field.
  wire        tx_sel_event = (txisel_reg == 2'h1) ? (tx_done & ~tx_out_valid)
                           : (txisel_reg == 2'h2) ? (tx_start
                             & (tx_count == 6'h01))
                           : tx_start;

  // Receive line: plain pin or stretched infrared pulses.
  wire        rx_line = ir_on ? (ir_hold_reg == 5'h00) : rx_sync_reg[1];
  wire        rx_sample = brg_tick & (rx_sub_reg == tpb - 5'h01);
  wire        rx_push = (rx_state_reg == uart_pkg::RX_STOP) & rx_sample;
  wire [8:0]  rx_char = nine_bit ? rx_shift_reg
                                 : {1'b0, rx_shift_reg[8:1]};
  wire [10:0] rx_word = {rx_parity_error_flag_reg, ~rx_line, rx_char};
  wire        rx_level = (rxisel_reg == 2'h2) ? (rx_count >= uart_pkg::RX_NEAR_FULL)
                       : (rxisel_reg == 2'h3) ? ~rx_in_ready
                       : rx_out_valid;

  // Register read mux.
  wire [15:0] stat_word = {txisel_reg, 2'h0, send_break_bit_reg, transmit_enable_bit_reg,
                           ~tx_in_ready,
                           (tx_state_reg == uart_pkg::TX_IDLE) & ~tx_out_valid,
                           rxisel_reg, 2'h0, rx_out_data[10], rx_out_data[9],
                           receive_overrun_flag_reg, rx_out_valid};
  wire [15:0] rd_word = (haddr[7:0] == uart_pkg::MODE_OFS) ? mode_reg
                      : (haddr[7:0] == uart_pkg::STAT_OFS) ? stat_word
                      : (haddr[7:0] == uart_pkg::RXD_OFS)
                        ? {7'h00, rx_out_data[8:0]}
                      : (haddr[7:0] == uart_pkg::BRG_OFS) ? brg_reg
                      : 16'h0000;

  assign hreadyout             = ~tx_stall;
  assign hresp                 = 1'b0;
  assign hrdata                = hrdata_reg;
  assign serial_transmit_pin   = tx_pin_reg;
  assign serial_transmit_oe    = mode_en;
  assign request_to_send_pin_n = rts_reg;
  assign request_to_send_oe    = mode_en & (pin_enable_field != 2'h0);
  assign tx_irq                = tx_irq_reg;
  assign rx_irq                = rx_irq_reg;

  char_fifo #(.WIDTH(uart_pkg::TX_WIDTH), .DEPTH(uart_pkg::FIFO_DEPTH)) tx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (hwdata[8:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_start),
    .out_data  (tx_out_data),
    .count     (tx_count)
  );

  char_fifo #(.WIDTH(uart_pkg::RX_WIDTH), .DEPTH(uart_pkg::FIFO_DEPTH)) rx_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (rx_word),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data),
    .count     (rx_count)
  );

  // Bus slave and registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg  <= 1'b0;
      dp_ofs_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      mode_reg   <= uart_pkg::MODE_RST;
      brg_reg    <= uart_pkg::BRG_RST;
      txisel_reg <= 2'h0;
      rxisel_reg <= 2'h0;
      transmit_enable_bit_reg  <= 1'b0;
      send_break_bit_reg <= 1'b0;
      receive_overrun_flag_reg   <= 1'b0;
    end else begin
      if (hready) begin
        dp_wr_reg  <= addr_ok & hwrite;
        dp_ofs_reg <= haddr[7:0];
      end
      if (addr_ok & ~hwrite) begin
        hrdata_reg <= {16'h0000, rd_word};
      end
      if (wr_mode) begin
        mode_reg <= hwdata[15:0];
      end
      if (wr_brg) begin
        brg_reg <= hwdata[15:0];
      end
      if (wr_stat) begin
        txisel_reg <= hwdata[uart_pkg::STAT_TXISEL_LSB +: 2];
        rxisel_reg <= hwdata[uart_pkg::STAT_RXISEL_LSB +: 2];
        transmit_enable_bit_reg  <= hwdata[uart_pkg::STAT_TXEN_BIT];
      end
      // A software write to the status word wins over the hardware clear.
      if (wr_stat) begin
        send_break_bit_reg <= hwdata[uart_pkg::STAT_TXBRK_BIT];
      end else if (brk_done) begin
        send_break_bit_reg <= 1'b0;
      end
      // Overrun is only cleared by software; a new overrun wins.
      if (rx_push & ~rx_in_ready) begin
        receive_overrun_flag_reg <= 1'b1;
      end else if (wr_stat) begin
        receive_overrun_flag_reg <= receive_overrun_flag_reg & hwdata[uart_pkg::STAT_RECEIVE_OVERRUN_FLAG_BIT];
      end
    end
  end

  // Synchronisers, baud generator, interrupts and pin drivers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_sync_reg  <= 2'h3;
      cts_sync_reg <= 2'h3;
      brg_cnt_reg  <= 16'h0000;
      bclk_reg     <= 1'b0;
      txen_d1_reg  <= 1'b0;
      txen_d2_reg  <= 1'b0;
      tx_irq_reg   <= 1'b0;
      rx_irq_reg   <= 1'b0;
      tx_pin_reg   <= 1'b1;
      rts_reg      <= 1'b1;
      ir_hold_reg  <= 5'h00;
    end else begin
      rx_sync_reg  <= {rx_sync_reg[0], serial_receive_pin};
      cts_sync_reg <= {cts_sync_reg[0], clear_to_send_pin_n};
      brg_cnt_reg  <= (brg_restart | brg_tick) ?
                      (brg_restart ? 16'h0000 : brg_reg)
                      : brg_cnt_reg - 16'h0001;
      // The 16x clock is high for roughly the upper half of each tick.
      bclk_reg     <= (brg_cnt_reg > {1'b0, brg_reg[15:1]});
      txen_d1_reg  <= transmit_enable_bit_reg;
      txen_d2_reg  <= txen_d1_reg;
      tx_irq_reg   <= (txen_d1_reg & ~txen_d2_reg)
                      | tx_sel_event;
      rx_irq_reg   <= rx_level;
      tx_pin_reg   <= mode_en ? tx_line : ~ir_on;
      if (pin_enable_field == 2'h3) begin
        rts_reg <= bclk_reg;
      end else begin
        rts_reg <= (rx_count >= uart_pkg::RX_NEAR_FULL);
      end
      // A low infrared pulse holds the decoded line low for one bit.
      if (!rx_sync_reg[1]) begin
        ir_hold_reg <= tpb;
      end else if (brg_tick & (ir_hold_reg != 5'h00)) begin
        ir_hold_reg <= ir_hold_reg - 5'h01;
      end
    end
  end

  // Transmitter; the break replaces the dummy character it was started by.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state_reg <= uart_pkg::TX_IDLE;
      tx_sub_reg   <= 5'h00;
      tx_cnt_reg   <= 4'h0;
      tx_shift_reg <= 9'h000;
      tx_par_reg   <= 1'b0;
    end else if (!mode_en) begin
      tx_state_reg <= uart_pkg::TX_IDLE;
    end else begin
      if (brg_tick) begin
        tx_sub_reg <= tx_bit_end ? 5'h00 : tx_sub_reg + 5'h01;
      end
      unique case (tx_state_reg)
        uart_pkg::TX_IDLE: begin
          tx_sub_reg <= 5'h00;
          tx_cnt_reg <= 4'h0;
          if (tx_start) begin
            tx_state_reg <= send_break_bit_reg ? uart_pkg::TX_BREAK
                                       : uart_pkg::TX_START;
            tx_shift_reg <= tx_char;
            tx_par_reg   <= (^tx_char) ^ par_odd;
          end
        end
        uart_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_state_reg <= uart_pkg::TX_DATA;
          end
        end
        uart_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            tx_cnt_reg   <= (tx_cnt_reg == last_bit) ? 4'h0
                                                     : tx_cnt_reg + 4'h1;
            if (tx_cnt_reg == last_bit) begin
              tx_state_reg <= par_en ? uart_pkg::TX_PAR : uart_pkg::TX_STOP;
            end
          end
        end
        uart_pkg::TX_PAR: begin
          if (tx_bit_end) begin
            tx_state_reg <= uart_pkg::TX_STOP;
          end
        end
        uart_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_cnt_reg   <= tx_cnt_reg + 4'h1;
            tx_state_reg <= tx_done ? uart_pkg::TX_IDLE : uart_pkg::TX_STOP;
          end
        end
        uart_pkg::TX_BREAK: begin
          if (tx_bit_end) begin
            tx_cnt_reg <= brk_done ? 4'h0 : tx_cnt_reg + 4'h1;
            if (brk_done) begin
              // The queued sync character follows the stop bit.
              tx_state_reg <= uart_pkg::TX_STOP;
            end
          end
        end
      endcase
    end
  end

  // Receiver: start bit is checked at its middle, then one sample per bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
      rx_sub_reg   <= 5'h00;
      rx_cnt_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_parity_error_flag_reg  <= 1'b0;
    end else if (!mode_en) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
    end else begin
      if (brg_tick) begin
        rx_sub_reg <= rx_sample ? 5'h00 : rx_sub_reg + 5'h01;
      end
      unique case (rx_state_reg)
        uart_pkg::RX_IDLE: begin
          rx_sub_reg  <= 5'h00;
          rx_cnt_reg  <= 4'h0;
          rx_parity_error_flag_reg <= 1'b0;
          if (!rx_line) begin
            rx_state_reg <= uart_pkg::RX_START;
          end
        end
        uart_pkg::RX_START: begin
          if (brg_tick & (rx_sub_reg == {1'b0, tpb[4:1]} - 5'h01)) begin
            rx_sub_reg   <= 5'h00;
            rx_state_reg <= rx_line ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        end
        uart_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
            rx_cnt_reg   <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == last_bit) begin
              rx_state_reg <= par_en ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
            end
          end
        end
        uart_pkg::RX_PAR: begin
          if (rx_sample) begin
            rx_parity_error_flag_reg  <= rx_line ^ (^rx_char) ^ par_odd;
            rx_state_reg <= uart_pkg::RX_STOP;
          end
        end
        uart_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= uart_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ---- tb/uart_tx_rx_break_irda_assertions.sv ----
// Checker on the transceiver ports: bus answers, pin enables, tx timing.
// Assumes hready is tied to hreadyout and a baud divisor from 1 to 15.
`timescale 1ns/100ps
module uart_checker (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pins.
  input wire logic        serial_transmit_pin,
  input wire logic        serial_transmit_oe,
  input wire logic        request_to_send_pin_n,
  input wire logic        request_to_send_oe,
  input wire logic        tx_irq
);
  logic [9:0]  ph_reg;
  logic [15:0] mode_reg;
  logic        txen_reg;
  wire logic   wr = hready && ph_reg[9] && ph_reg[8];
  wire logic   on = mode_reg[15];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_reg   <= 10'h000;
      mode_reg <= 16'h0000;
      txen_reg <= 1'b0;
    end else begin
      if (hready) ph_reg <= {hsel && htrans[1], hwrite, haddr[7:0]};
      if (wr && ph_reg[7:0] == uart_pkg::MODE_OFS) mode_reg <= hwdata[15:0];
      if (wr && ph_reg[7:0] == uart_pkg::STAT_OFS) txen_reg <= hwdata[10];
    end
  end
  sequence txen_up;
    wr && ph_reg[7:0] == uart_pkg::STAT_OFS && hwdata[10] && !txen_reg;
  endsequence
  sequence bclk_on;
    on && mode_reg[9:8] == 2'b11 && !mode_reg[3];
  endsequence
  AST_TXEN_IRQ:
    assert property (txen_up |-> ##[1:3] tx_irq) else $error("tx irq late");
  AST_TX_OE:
    assert property (on |-> ##[0:1] serial_transmit_oe) else $error("tx oe");
  AST_RTS_OE:
    assert property (on && mode_reg[9:8] != 2'b00 |-> ##[0:1]
      request_to_send_oe) else $error("rts oe");
  AST_BCLK:
    assert property (bclk_on |-> ##[1:8] $changed(request_to_send_pin_n))
    else $error("no baud clock");
  AST_BIT_LEN:
    assert property ($fell(serial_transmit_pin) && !mode_reg[12] |->
      !serial_transmit_pin [*4]) else $error("low bit too short");
  AST_STALL:
    assert property (!hreadyout |-> ph_reg[9:8] == 2'b11 &&
      ph_reg[7:0] == uart_pkg::TXD_OFS) else $error("wait state");
  AST_UNMAPPED:
    assert property (hready && ph_reg[9:8] == 2'b10 &&
      ph_reg[7:0] > uart_pkg::BRG_OFS |-> hrdata == 32'h0)
    else $error("unmapped read");
  AST_OKAY:
    assert property (hresp == 1'b0) else $error("error response");
endmodule
bind uart_tx_rx_break_irda uart_checker chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .serial_transmit_pin, .serial_transmit_oe, .request_to_send_pin_n,
  .request_to_send_oe, .tx_irq);

// ---- tb/serial_terminal_model.sv ----
// Remote terminal on the serial pins: logs and sends 8N1 characters.
// Assumes BIT_CLKS hclk cycles a bit; its line idles high as if pulled up.
`timescale 1ns/100ps
module serial_terminal_model #(
  parameter int BIT_CLKS = 4
) (
  // Clock.
  input wire logic   hclk,
  // Line from and line to the device.
  input wire logic   tx_line,
  output logic       rx_line,
  // Last character heard and how many.
  output logic [7:0] last_char,
  output logic [7:0] chars_seen
);
  logic [7:0] shift_reg;
  // Sampling mid-bit absorbs the clock by which the device's pin lags.
  initial begin
    rx_line <= 1'b1;
    last_char = 8'h00;
    chars_seen = 8'h00;
    forever begin
      @(negedge tx_line);
      repeat (BIT_CLKS / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge hclk);
        shift_reg[i] = tx_line;
      end
      wait (tx_line === 1'b1);
      last_char = shift_reg;
      chars_seen = chars_seen + 8'h01;
    end
  end
  task automatic send_char(input logic [7:0] c);
    for (int i = 0; i < 10; i++) begin
      rx_line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
      repeat (BIT_CLKS) @(posedge hclk);
    end
  endtask
endmodule

// ---- tb/uart_tx_rx_break_irda_test.sv ----
// Bench for the transceiver: registers over AHB-Lite, traffic through the
// terminal model, both FIFOs filled to refusal. Divisor 0, 4 clocks a bit.
`timescale 1ns/100ps
module uart_tx_rx_break_irda_test;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic        serial_receive_pin, serial_transmit_pin, serial_transmit_oe;
  logic        clear_to_send_pin_n, request_to_send_pin_n, request_to_send_oe;
  logic        tx_irq, rx_irq;
  logic [7:0]  last_char, chars_seen;
  int          err_count, checks_done;
  uart_tx_rx_break_irda dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .serial_receive_pin, .serial_transmit_pin,
    .serial_transmit_oe, .clear_to_send_pin_n, .request_to_send_pin_n,
    .request_to_send_oe, .tx_irq, .rx_irq);
  serial_terminal_model #(.BIT_CLKS(4)) term (.hclk,
    .tx_line(serial_transmit_pin), .rx_line(serial_receive_pin),
    .last_char, .chars_seen);
  always #20 hclk = ~hclk;
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready;
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 2000) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rdat = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask
  task automatic wait_chars(input logic [7:0] n, input logic [7:0] c);
    int k;
    for (k = 0; k < 4000; k++) begin
      if (chars_seen === n) break;
      @(posedge hclk);
    end
    chk({16'h0, chars_seen, last_char}, {16'h0, n, c});
    if (k == 4000) give_verdict();
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    clear_to_send_pin_n = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(uart_pkg::MODE_OFS, 32'hFFFF, {16'h0, uart_pkg::MODE_RST});
    rd(uart_pkg::BRG_OFS, 32'hFFFF, {16'h0, uart_pkg::BRG_RST});
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, uart_pkg::BRG_OFS, 32'h0);
    // Enabled, fast baud select, flow control on the clear-to-send pin.
    bus(1'b1, uart_pkg::MODE_OFS, 32'h8208);
    bus(1'b1, uart_pkg::TXD_OFS, 32'hA5);
    bus(1'b1, uart_pkg::STAT_OFS, 32'h0400);
    wait_chars(8'h01, 8'hA5);
    clear_to_send_pin_n <= 1'b1;
    for (int i = 0; i < 32; i++) bus(1'b1, uart_pkg::TXD_OFS, 32'h40 + i);
    rd(uart_pkg::STAT_OFS, 32'h0200, 32'h0200);
    fork
      bus(1'b1, uart_pkg::TXD_OFS, 32'h60);
      begin
        repeat (20) @(posedge hclk);
        chk({30'h0, hreadyout, chars_seen[0]}, 32'h1);
        clear_to_send_pin_n <= 1'b0;
      end
    join
    wait_chars(8'h22, 8'h60);
    bus(1'b1, uart_pkg::STAT_OFS, 32'h0C00);
    bus(1'b1, uart_pkg::TXD_OFS, 32'hFF);
    bus(1'b1, uart_pkg::TXD_OFS, 32'h55);
    wait_chars(8'h23, 8'h00);
    wait_chars(8'h24, 8'h55);
    rd(uart_pkg::STAT_OFS, 32'h0800, 32'h0);
    // Receive interrupt only while the receive FIFO is full.
    bus(1'b1, uart_pkg::STAT_OFS, 32'h04C0);
    for (int i = 0; i < 33; i++) term.send_char(8'hA0 + 8'(i));
    chk({31'h0, rx_irq}, 32'h1);
    chk({31'h0, request_to_send_pin_n}, 32'h1);
    for (int i = 0; i < 32; i++) begin
      rd(uart_pkg::RXD_OFS, 32'hFF, 32'hA0 + i);
      if (i == 1) chk({31'h0, rx_irq}, 32'h0);
    end
    rd(uart_pkg::STAT_OFS, 32'h3, 32'h2);
    chk({31'h0, request_to_send_pin_n}, 32'h0);
    bus(1'b1, uart_pkg::STAT_OFS, 32'h0);
    rd(uart_pkg::STAT_OFS, 32'h3, 32'h0);
    chk({31'h0, rx_irq}, 32'h0);
    // A divisor of one makes the 16x clock toggle on every hclk cycle;
    // with zero there is no half tick for a registered output to show.
    bus(1'b1, uart_pkg::BRG_OFS, 32'h1);
    bus(1'b1, uart_pkg::MODE_OFS, 32'h8300);
    rd(uart_pkg::MODE_OFS, 32'hFFFF, 32'h8300);
    chk({31'h0, request_to_send_oe}, 32'h1);
    rdat[0] = request_to_send_pin_n;
    @(posedge hclk);
    chk({31'h0, request_to_send_pin_n ^ rdat[0]}, 32'h1);
    repeat (10) @(posedge hclk);
    give_verdict();
  end
endmodule
